// File: core/fpg_pkg.sv
// package for the flash program/erase guard: offsets, bit positions, types
// assumes an 8-bit register port and an 18-bit flash byte address
package fpg_pkg;
   // register index on the plain register port
   localparam logic [2:0] ADDR_CTL_ONE = 3'h0;
   localparam logic [2:0] ADDR_CTL_TWO = 3'h1;
   localparam logic [2:0] ADDR_EBS_ONE = 3'h2;
   localparam logic [2:0] ADDR_EBS_TWO = 3'h3;
   localparam logic [2:0] ADDR_RAM_EMU = 3'h4;
   // control register bit positions (both control registers share the low bits)
   localparam int BIT_P = 0;
   localparam int BIT_E = 1;
   localparam int BIT_PV = 2;
   localparam int BIT_EV = 3;
   localparam int BIT_PSU = 4;
   localparam int BIT_ESU = 5;
   localparam int BIT_SWE = 6;
   localparam int BIT_FLASH_ERROR_FLAG = 7;
   // overlay control bit positions
   localparam int BIT_AREA_LO = 0;
   localparam int BIT_AREA_HI = 1;
   localparam int BIT_OVL_SEL = 3;
   // writable masks and values after reset
   localparam logic [7:0] MASK_CTL_ONE = 8'h7f;
   localparam logic [7:0] MASK_CTL_TWO = 8'h3f;
   localparam logic [7:0] MASK_RAM_EMU = 8'h0b;
   localparam logic [7:0] MASK_PE = 8'h03;
   localparam logic [7:0] RST_REG = 8'h00;
   // overlay window: 1 KiB blocks at the top of the array
   localparam logic [17:0] OVL_BASE = 18'h3f000;
   localparam logic [17:0] OVL_STEP = 18'h00400;
   localparam int OVL_OFS_W = 10;
   // synchroniser depth for pins
   localparam int SYNC_STAGES = 2;

   typedef enum logic [0:0] {
      FPG_ARMED = 1'b0,
      FPG_FAULT = 1'b1
   } fpg_err_e;

   // same-clock events from the cpu side
   typedef struct packed {
      logic flash_read;
      logic exception;
      logic sleep_exec;
      logic bus_release;
   } fpg_evt_s;

   // mode outputs toward the flash array
   typedef struct packed {
      logic program_mode;
      logic erase_mode;
      logic program_verify;
      logic erase_verify;
   } fpg_mode_s;
endpackage

// File: core/fpg_sync.sv
// two-flop level synchroniser for pins entering the mclk domain
// assumes the input is a slow level; glitches shorter than a cycle may be lost
`timescale 1ns/1ps
`default_nettype none
module fpg_sync #(
   parameter int STAGES = 2
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic din,
   output logic dout
);
   logic [STAGES-1:0] sh_r;
   logic [STAGES-1:0] sh_nxt;

   // shift toward the msb; only the last stage is visible outside
   always_comb begin
      sh_nxt = {sh_r[STAGES-2:0], din};
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sh_r <= '0;
      end else begin
         sh_r <= sh_nxt;
      end
   end

   assign dout = sh_r[STAGES-1];
endmodule
`default_nettype wire

// File: core/fpg_guard.sv
// flash program/erase guard: protection state, error monitor and ram overlay
// assumes cpu events arrive on mclk; write-protect and standby pins are async
`timescale 1ns/1ps
`default_nettype none
module fpg_guard (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic write_protect_pin,
   input wire logic hw_standby_pin,
   input wire logic soft_standby,
   input wire fpg_pkg::fpg_evt_s evt,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [17:0] flash_addr,
   output logic overlay_hit,
   output logic [9:0] overlay_ofs,
   output fpg_pkg::fpg_mode_s mode,
   output logic [15:0] erase_block_allow,
   output logic error_protected
);
   logic wp_s;
   logic hws_s;
   logic [7:0] c1_r, c1_nxt;
   logic [7:0] c2_r, c2_nxt;
   logic [7:0] eb1_r, eb1_nxt;
   logic [7:0] eb2_r, eb2_nxt;
   logic [7:0] ram_r, ram_nxt;
   fpg_pkg::fpg_err_e err_r, err_nxt;
   fpg_pkg::fpg_mode_s mode_r, mode_nxt;
   logic [15:0] ebk_r, ebk_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic hit_r, hit_nxt;
   logic [9:0] ofs_r, ofs_nxt;
   logic inhibit;
   logic inh_nxt;
   logic busy;
   logic fault_evt;
   logic init_regs;
   logic [1:0] area;
   logic [1:0] area_idx;
   logic [17:0] ovl_base;

   // pins cross into mclk through two flops before anything reads them
   fpg_sync #(.STAGES(fpg_pkg::SYNC_STAGES)) u_wp_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din(write_protect_pin),
      .dout(wp_s)
   );

   fpg_sync #(.STAGES(fpg_pkg::SYNC_STAGES)) u_hws_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din(hw_standby_pin),
      .dout(hws_s)
   );

   // one inhibit term for every protection source
   assign inhibit = wp_s | hws_s | soft_standby
      | ~c1_r[fpg_pkg::BIT_SWE]
      | ram_r[fpg_pkg::BIT_OVL_SEL]
      | (err_r == fpg_pkg::FPG_FAULT);
   assign busy = mode_r.program_mode | mode_r.erase_mode;
   // illegal events only count while a program or erase is under way
   assign fault_evt = busy & (evt.flash_read
      | evt.exception
      | evt.sleep_exec
      | evt.bus_release);
   // register init sources; the overlay register survives pin and standby init
   assign init_regs = wp_s | hws_s | soft_standby;

   // register file and error state
   always_comb begin
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      eb1_nxt = eb1_r;
      eb2_nxt = eb2_r;
      ram_nxt = ram_r;
      err_nxt = err_r;
      if (reg_wr) begin
         case (reg_addr)
            fpg_pkg::ADDR_CTL_ONE: begin
               // enables may be cleared but not set while inhibited
               c1_nxt = reg_wdata & fpg_pkg::MASK_CTL_ONE & ~fpg_pkg::MASK_PE;
               c1_nxt = c1_nxt | (reg_wdata & fpg_pkg::MASK_PE
                  & (inhibit ? c1_r : 8'hff));
            end
            fpg_pkg::ADDR_CTL_TWO: begin
               // error flag bit is read-only; software cannot clear it
               c2_nxt = (c2_r & ~fpg_pkg::MASK_CTL_TWO)
                  | (reg_wdata & fpg_pkg::MASK_CTL_TWO & ~fpg_pkg::MASK_PE);
               c2_nxt = c2_nxt | (reg_wdata & fpg_pkg::MASK_PE
                  & (inhibit ? c2_r : 8'hff));
            end
            fpg_pkg::ADDR_EBS_ONE: begin
               eb1_nxt = reg_wdata;
            end
            fpg_pkg::ADDR_EBS_TWO: begin
               eb2_nxt = reg_wdata;
            end
            fpg_pkg::ADDR_RAM_EMU: begin
               ram_nxt = reg_wdata & fpg_pkg::MASK_RAM_EMU;
            end
            default: begin
               c1_nxt = c1_r;
            end
         endcase
      end
      // error monitor: set wins, only hardware standby clears besides reset
      case (err_r)
         fpg_pkg::FPG_ARMED: begin
            if (fault_evt) begin
               err_nxt = fpg_pkg::FPG_FAULT;
            end
         end
         fpg_pkg::FPG_FAULT: begin
            if (hws_s && !fault_evt) begin
               err_nxt = fpg_pkg::FPG_ARMED;
            end
         end
         default: begin
            err_nxt = fpg_pkg::FPG_ARMED;
         end
      endcase
      // pin and standby init overrides any control or block-select write in the same cycle; an overlay register write still lands
      if (init_regs) begin
         c1_nxt = fpg_pkg::RST_REG;
         c2_nxt = fpg_pkg::RST_REG;
         eb1_nxt = fpg_pkg::RST_REG;
         eb2_nxt = fpg_pkg::RST_REG;
      end
      // the flag lives in the second control register; the rest is kept on error
      c2_nxt[fpg_pkg::BIT_FLASH_ERROR_FLAG] = (err_nxt == fpg_pkg::FPG_FAULT);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         c1_r <= fpg_pkg::RST_REG;
         c2_r <= fpg_pkg::RST_REG;
         eb1_r <= fpg_pkg::RST_REG;
         eb2_r <= fpg_pkg::RST_REG;
         ram_r <= fpg_pkg::RST_REG;
         err_r <= fpg_pkg::FPG_ARMED;
      end else begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         eb1_r <= eb1_nxt;
         eb2_r <= eb2_nxt;
         ram_r <= ram_nxt;
         err_r <= err_nxt;
      end
   end

   // modes follow the next register values so an abort takes effect on the flag's edge
   always_comb begin
      inh_nxt = init_regs | ~c1_nxt[fpg_pkg::BIT_SWE]
         | ram_nxt[fpg_pkg::BIT_OVL_SEL]
         | (err_nxt == fpg_pkg::FPG_FAULT);
      mode_nxt.program_mode = (c1_nxt[fpg_pkg::BIT_P] | c2_nxt[fpg_pkg::BIT_P]) & ~inh_nxt;
      mode_nxt.erase_mode = (c1_nxt[fpg_pkg::BIT_E] | c2_nxt[fpg_pkg::BIT_E]) & ~inh_nxt
         & ((eb1_nxt | eb2_nxt) != 8'h00);
      // verify stays reachable in error protection, still needs write enable
      mode_nxt.program_verify = (c1_nxt[fpg_pkg::BIT_PV] | c2_nxt[fpg_pkg::BIT_PV])
         & c1_nxt[fpg_pkg::BIT_SWE] & ~init_regs;
      mode_nxt.erase_verify = (c1_nxt[fpg_pkg::BIT_EV] | c2_nxt[fpg_pkg::BIT_EV])
         & c1_nxt[fpg_pkg::BIT_SWE] & ~init_regs;
      // block selection gates erase only, never programming
      ebk_nxt = {eb2_nxt, eb1_nxt} & {16{mode_nxt.erase_mode}};
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_r <= '0;
         ebk_r <= 16'h0000;
      end else begin
         mode_r <= mode_nxt;
         ebk_r <= ebk_nxt;
      end
   end

   // overlay window base from the two area bits: 01 gives the eighth block at 3f000
   assign area = {ram_r[fpg_pkg::BIT_AREA_HI], ram_r[fpg_pkg::BIT_AREA_LO]};
   // the step index wraps in two bits, so area 00 lands on the topmost block, not below the base
   assign area_idx = area - 2'd1;
   assign ovl_base = fpg_pkg::OVL_BASE + (fpg_pkg::OVL_STEP * {16'h0000, area_idx});

   // overlay decode is registered, one cycle behind the flash address
   always_comb begin
      // no mode dependency: emulation works the same in user and user program mode
      hit_nxt = ram_r[fpg_pkg::BIT_OVL_SEL]
         & (flash_addr[17:fpg_pkg::OVL_OFS_W] == ovl_base[17:fpg_pkg::OVL_OFS_W]);
      ofs_nxt = flash_addr[fpg_pkg::OVL_OFS_W-1:0];
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hit_r <= 1'b0;
         ofs_r <= 10'h000;
      end else begin
         hit_r <= hit_nxt;
         ofs_r <= ofs_nxt;
      end
   end

   // read data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      rd_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            fpg_pkg::ADDR_CTL_ONE: rd_nxt = c1_r;
            fpg_pkg::ADDR_CTL_TWO: rd_nxt = c2_r;
            fpg_pkg::ADDR_EBS_ONE: rd_nxt = eb1_r;
            fpg_pkg::ADDR_EBS_TWO: rd_nxt = eb2_r;
            fpg_pkg::ADDR_RAM_EMU: rd_nxt = ram_r;
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_r <= 8'h00;
      end else begin
         rd_r <= rd_nxt;
      end
   end

   assign reg_rdata = rd_r;
   assign mode = mode_r;
   assign erase_block_allow = ebk_r;
   assign overlay_hit = hit_r;
   assign overlay_ofs = ofs_r;
   assign error_protected = c2_r[fpg_pkg::BIT_FLASH_ERROR_FLAG];

   // checks on the guard's own registers and outputs
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence busy_fault_s;
      busy && fault_evt;
   endsequence

   sequence flag_raised_s;
      ##1 error_protected && !busy;
   endsequence

   wp_init_a: assert property (wp_s |=> (c1_r == 8'h00) && (eb1_r == 8'h00) && (eb2_r == 8'h00))
      else $error("write protect pin did not clear registers");

   stby_init_a: assert property (soft_standby |=> !busy && (eb2_r == 8'h00))
      else $error("standby did not enter protection");

   swe_guard_a: assert property (busy |-> c1_r[fpg_pkg::BIT_SWE])
      else $error("mode active without software write enable");

   erase_sel_a: assert property (mode_r.erase_mode |-> ((eb1_r | eb2_r) != 8'h00))
      else $error("erase mode with no block selected");

   ovl_prot_a: assert property (ram_r[fpg_pkg::BIT_OVL_SEL] |-> !busy)
      else $error("mode active under overlay select");

   fault_abort_a: assert property (busy_fault_s |-> flag_raised_s)
      else $error("fault event did not raise flag and abort");

   err_lock_a: assert property (error_protected |-> !busy)
      else $error("mode active in error protection");

   flag_keep_a: assert property (error_protected && !hws_s |=> error_protected)
      else $error("error flag cleared without reset or standby");

   flag_cause_a: assert property ($rose(error_protected) |-> $past(busy))
      else $error("error flag rose while idle");

   ovl_map_a: assert property (ram_r[fpg_pkg::BIT_OVL_SEL] && $stable(ram_r) && flash_addr[17:10] == 8'hfc
      && area == 2'b01 |=> overlay_hit)
      else $error("eighth block not overlaid");

   ovl_off_a: assert property (!ram_r[fpg_pkg::BIT_OVL_SEL] |=> !overlay_hit)
      else $error("overlay hit with overlay off");

   // pin and standby protection
   wp_block_a: assert property (wp_s |=> !busy)
      else $error("mode active under write protect pin");

   ctl_two_init_a: assert property (init_regs |=> c2_r[6:0] == 7'h00)
      else $error("second control register not initialised");

   // erase gating by block selection
   erase_allow_a: assert property (erase_block_allow != 16'h0000 |-> mode_r.erase_mode)
      else $error("block allow without erase mode");

   // regs kept on abort; only meaningful when software and init stay quiet that cycle
   sequence regs_kept_s;
      ##1 (c1_r == $past(c1_r)) && (eb1_r == $past(eb1_r)) && (eb2_r == $past(eb2_r));
   endsequence

   abort_keep_a: assert property (busy && fault_evt && !reg_wr && !init_regs |-> regs_kept_s)
      else $error("registers changed on error abort");

   hws_clear_a: assert property (error_protected && hws_s && !fault_evt |=> !error_protected)
      else $error("hardware standby did not clear error flag");

   // verify access survives error protection
   pv_reach_a: assert property (c1_r[fpg_pkg::BIT_PV] && c1_r[fpg_pkg::BIT_SWE] |-> mode_r.program_verify)
      else $error("program verify not entered");

   ev_reach_a: assert property (c1_r[fpg_pkg::BIT_EV] && c1_r[fpg_pkg::BIT_SWE] |-> mode_r.erase_verify)
      else $error("erase verify not entered");

   // read data stand only one cycle, so a late sample sees zero rather than stale data
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside the read cycle");
endmodule
`default_nettype wire

// File: testbench/fpg_cpu_model.sv
// cpu-side partner: register port master and one-cycle event source
// assumes the guard samples every input on the rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module fpg_cpu_model (
   input wire logic mclk,
   output logic [2:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   output fpg_pkg::fpg_evt_s evt
);
   // idle bus from time zero; no nmi source is modelled, so it stays off
   initial begin
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      evt = '0;
   end
   // one write cycle; returns just after the taking edge has settled
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one read cycle; data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // single-cycle event pulse, as the cpu raises it
   task automatic pulse(input logic [3:0] v);
      @(posedge mclk);
      evt <= fpg_pkg::fpg_evt_s'(v);
      @(posedge mclk);
      evt <= '0;
      #1;
   endtask
endmodule
`default_nettype wire

// File: testbench/test_fpg_guard.sv
// self-checking bench for the flash program/erase guard
// assumes fpg_guard and the cpu partner model; regs are reached only through the partner
`timescale 1ns/1ps
`default_nettype none
module test_fpg_guard;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic write_protect_pin = 1'b0;
   logic hw_standby_pin = 1'b0;
   logic soft_standby = 1'b0;
   logic [17:0] flash_addr = 18'h00000;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] rv;
   logic overlay_hit;
   logic [9:0] overlay_ofs;
   logic [15:0] erase_block_allow;
   logic error_protected;
   fpg_pkg::fpg_evt_s evt;
   fpg_pkg::fpg_mode_s mode;
   int num_errors = 0;
   int tests_run = 0;
   // 50 MHz clock
   always #10 mclk = ~mclk;
   fpg_guard u_dut (.mclk(mclk), .sys_rst(sys_rst), .write_protect_pin(write_protect_pin),
      .hw_standby_pin(hw_standby_pin), .soft_standby(soft_standby), .evt(evt), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_addr(flash_addr), .overlay_hit(overlay_hit), .overlay_ofs(overlay_ofs), .mode(mode),
      .erase_block_allow(erase_block_allow), .error_protected(error_protected));
   fpg_cpu_model u_cpu (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt));
   // compare one value and count it
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   // three-cycle reset also flushes the pin synchronisers
   task automatic do_reset();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask
   // hold a pin level long enough to pass the synchroniser
   task automatic pins(input logic wp, input logic hs);
      @(posedge mclk);
      write_protect_pin <= wp;
      hw_standby_pin <= hs;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   // overlay decode is registered: answer one cycle after the address
   task automatic probe(input logic [17:0] a);
      @(posedge mclk);
      flash_addr <= a;
      @(posedge mclk);
      #1;
   endtask
   // reset values and an unmapped index
   task automatic t_reset();
      do_reset();
      for (int i = 0; i < 5; i++) begin
         u_cpu.rd(3'(i), rv);
         chk("reg after reset", 16'h0000, {8'h00, rv});
      end
      u_cpu.wr(3'h5, 8'hff);
      u_cpu.rd(3'h5, rv);
      chk("unmapped read", 16'h0000, {8'h00, rv});
   endtask
   // software write enable gates the modes; block selection gates erase only
   task automatic t_soft();
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h01);
      chk("program without swe", 16'h0000, {15'h0, mode.program_mode});
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h41);
      chk("program, no block selected", 16'h0001, {15'h0, mode.program_mode});
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h42);
      chk("erase with no block", 16'h0000, {15'h0, mode.erase_mode});
      u_cpu.wr(fpg_pkg::ADDR_EBS_TWO, 8'h10);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h42);
      chk("erase selected", 16'h0001, {15'h0, mode.erase_mode});
      chk("erase allow", 16'h1000, erase_block_allow);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
   endtask
   // overlay on block eight, emulation protection, then removal
   task automatic t_overlay();
      u_cpu.wr(fpg_pkg::ADDR_RAM_EMU, 8'h09);
      probe(18'h3f123);
      chk("overlay hit", 16'h0001, {15'h0, overlay_hit});
      chk("overlay offset", 16'h0123, {6'h0, overlay_ofs});
      probe(18'h3f400);
      chk("outside overlay", 16'h0000, {15'h0, overlay_hit});
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h42);
      chk("erase under overlay", 16'h0000, {15'h0, mode.erase_mode});
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h41);
      chk("program under overlay", 16'h0000, {15'h0, mode.program_mode});
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
      // area bits 00 select the topmost 1 KiB window
      u_cpu.wr(fpg_pkg::ADDR_RAM_EMU, 8'h08);
      probe(18'h3fc10);
      chk("overlay area zero", 16'h0001, {15'h0, overlay_hit});
      // overlay select is dropped before any real programming
      u_cpu.wr(fpg_pkg::ADDR_RAM_EMU, 8'h00);
      probe(18'h3fc10);
      chk("overlay removed", 16'h0000, {15'h0, overlay_hit});
   endtask
   // every event kind aborts a busy mode and latches the error
   task automatic t_errors();
      for (int i = 0; i < 4; i++) begin
         do_reset();
         u_cpu.wr(fpg_pkg::ADDR_EBS_ONE, 8'h01);
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
         u_cpu.pulse(4'h8 >> i);
         chk("event while idle", 16'h0000, {15'h0, error_protected});
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, i[0] ? 8'h42 : 8'h41);
         u_cpu.pulse(4'h8 >> i);
         chk("error flag", 16'h0001, {15'h0, error_protected});
         chk("mode aborted", 16'h0000, {12'h0, mode});
         u_cpu.rd(fpg_pkg::ADDR_CTL_ONE, rv);
         chk("ctl one kept", {8'h00, i[0] ? 8'h42 : 8'h41}, {8'h00, rv});
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h41);
         chk("re-enter program", 16'h0000, {15'h0, mode.program_mode});
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h44);
         chk("verify in error", 16'h0001, {15'h0, mode.program_verify});
         u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h48);
         chk("erase verify in error", 16'h0001, {15'h0, mode.erase_verify});
         u_cpu.wr(fpg_pkg::ADDR_CTL_TWO, 8'h00);
         u_cpu.rd(fpg_pkg::ADDR_CTL_TWO, rv);
         chk("flag not writable", 16'h0080, {8'h00, rv});
      end
   endtask
   // write-protect pin, hardware standby and software standby
   task automatic t_pins();
      pins(1'b0, 1'b1);
      pins(1'b0, 1'b0);
      chk("standby clears error", 16'h0000, {15'h0, error_protected});
      u_cpu.rd(fpg_pkg::ADDR_CTL_ONE, rv);
      chk("standby init", 16'h0000, {8'h00, rv});
      u_cpu.wr(fpg_pkg::ADDR_EBS_ONE, 8'h01);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h41);
      pins(1'b1, 1'b0);
      chk("wp aborts program", 16'h0000, {15'h0, mode.program_mode});
      u_cpu.rd(fpg_pkg::ADDR_EBS_ONE, rv);
      chk("wp init select", 16'h0000, {8'h00, rv});
      pins(1'b0, 1'b0);
      u_cpu.wr(fpg_pkg::ADDR_CTL_ONE, 8'h40);
      @(posedge mclk);
      soft_standby <= 1'b1;
      @(posedge mclk);
      soft_standby <= 1'b0;
      u_cpu.rd(fpg_pkg::ADDR_CTL_ONE, rv);
      chk("soft standby init", 16'h0000, {8'h00, rv});
   endtask
   // verdict in one place; used by the main sequence and the watchdog
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      t_reset();
      t_soft();
      t_overlay();
      t_errors();
      t_pins();
      print_verdict();
   end
   // the tests need well under 1000 cycles; ten times that means a hang
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
